//--- io_route_pkg.sv
// Shared constants and types for the I/O assignment and selector block.
// Assumes a 32-bit APB register port and a single module clock.
package io_route_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] DEST_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] DEB_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] DEB_END = 12'h080;
    localparam logic [ADDR_W-1:0] ASG_BASE = 12'h100;
    localparam int ASG_STRIDE_LG = 3;
    localparam int WORD_LG = 2;
    localparam int WORD_SEL_BIT = 2;

    // Field positions
    localparam int CTRL_CNT_LSB = 0;
    localparam int CTRL_DIR_LSB = 8;
    localparam int STAT_DEB_LSB = 0;
    localparam int STAT_DIO_LSB = 8;
    localparam int STAT_IDX_LSB = 16;
    localparam int STAT_FIRED_BIT = 24;
    localparam int ASG_SRC_LSB = 0;
    localparam int ASG_DST_LSB = 16;
    localparam int ASG_VALID_BIT = 31;
    localparam int ASG_POL_LSB = 0;
    localparam int ASG_CLR_LSB = 16;

    // Routing limits
    localparam int MAX_FANOUT = 10;
    localparam int SEL_MAX = 8;
    localparam int SEL_CNT_W = 4;
    localparam int NUM_DIO = 3;
    localparam int SRC_W = 9;
    localparam int DST_W = 5;
    localparam int POL_W = 2;

    typedef enum logic [POL_W-1:0] {
        POL_ON = 2'h0,
        POL_OFF = 2'h1,
        POL_CUSTOM = 2'h2
    } pol_t;

    typedef struct packed {
        logic valid;
        pol_t pol;
        logic [SRC_W-1:0] src;
        logic [SRC_W-1:0] clr;
        logic [DST_W-1:0] dst;
    } asg_t;

endpackage

//--- input_debounce.sv
// Synchroniser and debounce qualifier, one per digital input.
// Assumes pins are asynchronous to clock_i; limits come from registers.
`timescale 1ns/10ps
module input_debounce
    import io_route_pkg::*;
#(
    parameter int NUM_IN = 4,
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [NUM_IN-1:0] pin_i,
    input wire logic [NUM_IN-1:0][CNT_W-1:0] limit_i,
    output logic [NUM_IN-1:0] active_o
);

    logic [NUM_IN-1:0] meta_q;
    logic [NUM_IN-1:0] sync_q;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        logic [CNT_W-1:0] run_q;
        logic act_q;
        logic [CNT_W:0] held_q;

        // Any low sample restarts the interval
        always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
                run_q <= '0;
                act_q <= 1'b0;
            end else if (!sync_q[i]) begin
                run_q <= '0;
                act_q <= 1'b0;
            end else begin
                if (run_q < limit_i[i]) begin
                    run_q <= run_q + 1'b1;
                end
                act_q <= (run_q >= limit_i[i]);
            end
        end
        assign active_o[i] = act_q;

        // Independent run length, read only by the checks below
        always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
                held_q <= '0;
            end else if (!sync_q[i]) begin
                held_q <= '0;
            end else if (held_q != '1) begin
                held_q <= held_q + 1'b1;
            end
        end

        property p_deb_min;
            @(posedge clock_i) disable iff (!nrst_i)
            act_q |-> held_q > {1'b0, limit_i[i]};
        endproperty
        a_deb_min: assert property (p_deb_min)
            else $error("input accepted before debounce interval");

        property p_deb_drop;
            @(posedge clock_i) disable iff (!nrst_i)
            !sync_q[i] |=> !act_q;
        endproperty
        a_deb_drop: assert property (p_deb_drop)
            else $error("input stayed active after going low");

        c_deb_accept: cover property (@(posedge clock_i)
            disable iff (!nrst_i) $rose(act_q) && limit_i[i] > 1);
    end

endmodule

//--- binary_selector.sv
// Binary-to-one-hot selector with edge-triggered capture.
// Assumes select lines and trigger are already in the clock_i domain.
`timescale 1ns/10ps
module binary_selector
    import io_route_pkg::*;
#(
    parameter int SEL_N = SEL_MAX
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [SEL_N-1:0] select_i,
    input wire logic [SEL_CNT_W-1:0] count_i,
    input wire logic trigger_i,
    output logic [2**SEL_N-1:0] selection_o,
    output logic [SEL_N-1:0] index_o,
    output logic fired_o
);

    localparam int NSEL = 2**SEL_N;

    logic trig_q;
    logic rise;
    logic [SEL_N:0] span;
    logic [SEL_N-1:0] mask;
    logic [SEL_N-1:0] idx_d;

    // Lines above the configured count do not weigh in
    assign span = (SEL_N+1)'(1) << count_i;
    assign mask = SEL_N'(span - 1'b1);
    assign idx_d = select_i & mask;
    assign rise = trigger_i && !trig_q;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trigger_i;
        end
    end

    // Select lines are only looked at on the trigger edge
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            selection_o <= '0;
            index_o <= '0;
            fired_o <= 1'b0;
        end else if (rise) begin
            selection_o <= NSEL'(1) << idx_d;
            index_o <= idx_d;
            fired_o <= 1'b1;
        end else begin
            selection_o <= '0;
        end
    end

    property p_pick;
        @(posedge clock_i) disable iff (!nrst_i)
        rise |=> selection_o == (NSEL'(1) << $past(select_i & mask));
    endproperty
    a_pick: assert property (p_pick)
        else $error("wrong selection after trigger");

    property p_quiet;
        @(posedge clock_i) disable iff (!nrst_i)
        !rise |=> selection_o == '0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("selection changed without trigger edge");

    property p_range;
        @(posedge clock_i) disable iff (!nrst_i)
        rise |=> (selection_o >> $past(span)) == '0;
    endproperty
    a_range: assert property (p_range)
        else $error("selection beyond configured range");

    c_sel_pulse: cover property (@(posedge clock_i)
        disable iff (!nrst_i) rise ##1 trigger_i ##1 !trigger_i);

endmodule

//--- io_assignment_selector.sv
// Top of the I/O assignment block: routing table, polarity, selector,
// debounced inputs and three direction-configurable drive I/O points.
// Assumes an APB master on clock_i and asynchronous field pins.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module io_assignment_selector
    import io_route_pkg::*;
#(
    parameter int NUM_IN = 4,
    parameter int NUM_DEST = 16,
    parameter int NUM_ASG = 16,
    parameter int DEB_W = 16
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NUM_IN-1:0] din_i,
    input wire logic [NUM_DIO-1:0] dio_in_i,
    output logic [NUM_DIO-1:0] dio_out_o,
    output logic [NUM_DIO-1:0] dio_oe_o,
    output logic [NUM_DEST-1:0] dest_o
);

    localparam int NSEL = 2**SEL_MAX;
    localparam int ASG_IW = $clog2(NUM_ASG);
    localparam int FAN_W = $clog2(NUM_ASG + 1);
    localparam int SRC_SPAN = 2**SRC_W;
    localparam int DST_SPAN = 2**DST_W;
    localparam int SRC_USED = NUM_IN + NUM_DIO + NSEL;
    // Destination layout after the user destinations
    localparam int DIO_DST = NUM_DEST;
    localparam int SEL_DST = NUM_DEST + NUM_DIO;
    localparam int TRIG_DST = SEL_DST + SEL_MAX;
    localparam int DEB_IW = $clog2(NUM_IN);
    localparam logic [ADDR_W-1:0] ASG_END =
        ASG_BASE + ADDR_W'(NUM_ASG << ASG_STRIDE_LG);

    // Registers
    asg_t [NUM_ASG-1:0] asg_q;
    logic [NUM_ASG-1:0] cust_q;
    logic [DST_SPAN-1:0] dest_q;
    logic [SEL_CNT_W-1:0] sel_cnt_q;
    logic [NUM_DIO-1:0] dir_q;
    logic [NUM_DIO-1:0] dio_meta_q;
    logic [NUM_DIO-1:0] dio_sync_q;
    logic [NUM_DIO-1:0] dio_out_q;
    logic [NUM_IN-1:0][DEB_W-1:0] deb_lim_q;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Combinational
    logic setup;
    logic done;
    logic wr_ok;
    logic in_deb;
    logic in_asg;
    logic word_sel;
    logic [ADDR_W-1:0] asg_off;
    logic [ASG_IW-1:0] a_idx;
    logic [DEB_IW-1:0] d_idx;
    logic [FAN_W-1:0] fan_cnt;
    logic fan_full;
    logic [DATA_W-1:0] rdata_d;
    logic err_d;
    logic [NUM_ASG-1:0] contrib;
    logic [DST_SPAN-1:0] dest_d;
    logic [SRC_SPAN-1:0] srcv;
    logic [NUM_IN-1:0] deb_act;
    logic [NUM_DIO-1:0] dio_src;
    logic [NSEL-1:0] selection;
    logic [SEL_MAX-1:0] sel_index;
    logic sel_fired;
    logic [SEL_CNT_W-1:0] cnt_wr;

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign dio_out_o = dio_out_q;
    assign dio_oe_o = dir_q;
    assign dest_o = dest_q[NUM_DEST-1:0];

    // APB phases: one wait-free access phase after each setup
    assign setup = psel_i && !penable_i;
    assign done = psel_i && penable_i && pready_q;
    assign wr_ok = done && pwrite_i && !pslverr_q;

    assign asg_off = paddr_i - ASG_BASE;
    assign a_idx = asg_off[ASG_STRIDE_LG +: ASG_IW];
    assign word_sel = paddr_i[WORD_SEL_BIT];
    assign d_idx = paddr_i[WORD_LG +: DEB_IW];
    assign in_asg = paddr_i >= ASG_BASE && paddr_i < ASG_END;
    assign in_deb = paddr_i >= DEB_BASE && paddr_i < DEB_END
        && paddr_i < DEB_BASE + ADDR_W'(NUM_IN << WORD_LG);

    // Other enabled entries already driven by the incoming source
    always_comb begin
        fan_cnt = '0;
        for (int k = 0; k < NUM_ASG; k++) begin
            if (asg_q[k].valid && ASG_IW'(k) != a_idx
                && asg_q[k].src == pwdata_i[ASG_SRC_LSB +: SRC_W]) begin
                fan_cnt = fan_cnt + 1'b1;
            end
        end
    end

    assign fan_full = in_asg && !word_sel && pwrite_i
        && pwdata_i[ASG_VALID_BIT]
        && fan_cnt >= FAN_W'(MAX_FANOUT);

    // Read mux and error decode, evaluated in the setup cycle
    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        if (paddr_i[WORD_LG-1:0] != '0) begin
            err_d = 1'b1;
        end else if (paddr_i == CTRL_ADDR) begin
            rdata_d[CTRL_CNT_LSB +: SEL_CNT_W] = sel_cnt_q;
            rdata_d[CTRL_DIR_LSB +: NUM_DIO] = dir_q;
        end else if (paddr_i == STAT_ADDR) begin
            rdata_d[STAT_DEB_LSB +: NUM_IN] = deb_act;
            rdata_d[STAT_DIO_LSB +: NUM_DIO] = dio_sync_q;
            rdata_d[STAT_IDX_LSB +: SEL_MAX] = sel_index;
            rdata_d[STAT_FIRED_BIT] = sel_fired;
            err_d = pwrite_i;
        end else if (paddr_i == DEST_ADDR) begin
            rdata_d = dest_q;
            err_d = pwrite_i;
        end else if (in_deb) begin
            rdata_d[DEB_W-1:0] = deb_lim_q[d_idx];
        end else if (in_asg && !word_sel) begin
            rdata_d[ASG_VALID_BIT] = asg_q[a_idx].valid;
            rdata_d[ASG_SRC_LSB +: SRC_W] = asg_q[a_idx].src;
            rdata_d[ASG_DST_LSB +: DST_W] = asg_q[a_idx].dst;
            err_d = fan_full;
        end else if (in_asg) begin
            rdata_d[ASG_POL_LSB +: POL_W] = asg_q[a_idx].pol;
            rdata_d[ASG_CLR_LSB +: SRC_W] = asg_q[a_idx].clr;
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= err_d;
                prdata_q <= pwrite_i ? '0 : rdata_d;
            end else if (done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Counts above the selector's width are clamped, not refused
    assign cnt_wr = (pwdata_i[CTRL_CNT_LSB +: SEL_CNT_W]
        > SEL_CNT_W'(SEL_MAX)) ? SEL_CNT_W'(SEL_MAX)
        : pwdata_i[CTRL_CNT_LSB +: SEL_CNT_W];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_cnt_q <= '0;
            dir_q <= '0;
        end else if (wr_ok && paddr_i == CTRL_ADDR) begin
            sel_cnt_q <= cnt_wr;
            dir_q <= pwdata_i[CTRL_DIR_LSB +: NUM_DIO];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            deb_lim_q <= '0;
        end else if (wr_ok && in_deb) begin
            deb_lim_q[d_idx] <= pwdata_i[DEB_W-1:0];
        end
    end

    // Routing table; unknown polarity codes fall back to active-on
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            asg_q <= '0;
        end else if (wr_ok && in_asg && !word_sel) begin
            asg_q[a_idx].valid <= pwdata_i[ASG_VALID_BIT];
            asg_q[a_idx].src <= pwdata_i[ASG_SRC_LSB +: SRC_W];
            asg_q[a_idx].dst <= pwdata_i[ASG_DST_LSB +: DST_W];
            asg_q[a_idx].pol <= POL_ON;
        end else if (wr_ok && in_asg) begin
            case (pwdata_i[ASG_POL_LSB +: POL_W])
                POL_OFF: asg_q[a_idx].pol <= POL_OFF;
                POL_CUSTOM: asg_q[a_idx].pol <= POL_CUSTOM;
                default: asg_q[a_idx].pol <= POL_ON;
            endcase
            asg_q[a_idx].clr <= pwdata_i[ASG_CLR_LSB +: SRC_W];
        end
    end

    // Drive I/O pins are asynchronous: two stages before use
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dio_meta_q <= '0;
            dio_sync_q <= '0;
        end else begin
            dio_meta_q <= dio_in_i;
            dio_sync_q <= dio_meta_q;
        end
    end

    // A point set as output never acts as a source
    assign dio_src = dio_sync_q & ~dir_q;

    // Unused source codes read as inactive
    assign srcv = {{(SRC_SPAN - SRC_USED){1'b0}},
        selection, dio_src, deb_act};

    for (genvar k = 0; k < NUM_ASG; k++) begin : g_asg
        // Set has priority when both sources are active together
        always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
                cust_q[k] <= 1'b0;
            end else if (srcv[asg_q[k].src]) begin
                cust_q[k] <= 1'b1;
            end else if (srcv[asg_q[k].clr]) begin
                cust_q[k] <= 1'b0;
            end
        end

        always_comb begin
            case (asg_q[k].pol)
                POL_ON: contrib[k] = srcv[asg_q[k].src];
                POL_OFF: contrib[k] = !srcv[asg_q[k].src];
                POL_CUSTOM: contrib[k] = cust_q[k];
                default: contrib[k] = 1'b0;
            endcase
        end
    end

    // Fan-in is unbounded: every enabled entry may hit the same bit
    always_comb begin
        dest_d = '0;
        for (int k = 0; k < NUM_ASG; k++) begin
            if (asg_q[k].valid && contrib[k]) begin
                dest_d[asg_q[k].dst] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dest_q <= '0;
            dio_out_q <= '0;
        end else begin
            dest_q <= dest_d;
            dio_out_q <= dest_d[DIO_DST +: NUM_DIO] & dir_q;
        end
    end

    input_debounce #(
        .NUM_IN(NUM_IN),
        .CNT_W(DEB_W)
    ) u_debounce (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .pin_i(din_i),
        .limit_i(deb_lim_q),
        .active_o(deb_act)
    );

    // Registered destinations feed the selector, so no loop forms
    binary_selector #(
        .SEL_N(SEL_MAX)
    ) u_selector (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .select_i(dest_q[SEL_DST +: SEL_MAX]),
        .count_i(sel_cnt_q),
        .trigger_i(dest_q[TRIG_DST]),
        .selection_o(selection),
        .index_o(sel_index),
        .fired_o(sel_fired)
    );

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    property p_fanout;
        setup && fan_full |=> pready_o && pslverr_o;
    endproperty
    a_fanout: assert property (p_fanout)
        else $error("eleventh fan-out from one source accepted");

    property p_on;
        asg_q[0].valid && asg_q[0].pol == POL_ON && srcv[asg_q[0].src]
        |=> dest_q[$past(asg_q[0].dst)];
    endproperty
    a_on: assert property (p_on)
        else $error("active-on destination did not follow source");

    property p_off;
        asg_q[0].valid && asg_q[0].pol == POL_OFF && !srcv[asg_q[0].src]
        |=> dest_q[$past(asg_q[0].dst)];
    endproperty
    a_off: assert property (p_off)
        else $error("active-off destination not set by idle source");

    property p_custom;
        asg_q[0].valid && asg_q[0].pol == POL_CUSTOM
        && srcv[asg_q[0].src]
        ##1 asg_q[0].valid && asg_q[0].pol == POL_CUSTOM
        |=> dest_q[$past(asg_q[0].dst)];
    endproperty
    a_custom: assert property (p_custom)
        else $error("custom set source did not raise destination");

    property p_new_on;
        wr_ok && in_asg && !word_sel
        |=> asg_q[$past(a_idx)].pol == POL_ON;
    endproperty
    a_new_on: assert property (p_new_on)
        else $error("new assignment not active-on");

    property p_cnt_cap;
        wr_ok && paddr_i == CTRL_ADDR
        |=> sel_cnt_q <= SEL_CNT_W'(SEL_MAX);
    endproperty
    a_cnt_cap: assert property (p_cnt_cap)
        else $error("select line count above eight");

    property p_dio_in;
        !dir_q[0] ##1 !dir_q[0] |-> !dio_out_o[0];
    endproperty
    a_dio_in: assert property (p_dio_in)
        else $error("drive point configured as input is driven");

    c_fan_refused: cover property (setup && fan_full);
    c_two_sources: cover property (asg_q[0].valid && asg_q[1].valid
        && asg_q[0].dst == asg_q[1].dst && contrib[0] && contrib[1]);

endmodule

//--- field_wiring.sv
// Field wiring model: drives the digital inputs and drive I/O pins.
// Assumes the bench sets wanted levels; the pins have no pull.
`timescale 1ns/10ps
module field_wiring (
    input wire logic [3:0] lvl_i,
    input wire logic [2:0] dio_lvl_i,
    input wire logic [2:0] dio_out_i,
    input wire logic [2:0] dio_oe_i,
    output logic [3:0] din_o,
    output logic [2:0] dio_in_o
);
    // Start lines are wired active high, so lost power reads inactive
    assign din_o = lvl_i;
    // A point the block drives shows the block's own level
    assign dio_in_o = (dio_oe_i & dio_out_i) | (~dio_oe_i & dio_lvl_i);
endmodule

//--- io_assignment_selector_tb_top.sv
// Self-checking bench for io_assignment_selector.
// Assumes the field wiring model sits on the pins; APB master at 50 MHz.
`timescale 1ns/10ps
module io_assignment_selector_tb_top;
    import io_route_pkg::*;
    logic clock_i = 0;
    logic nrst_i = 0;
    logic psel_i = 0;
    logic penable_i = 0;
    logic pwrite_i = 0;
    logic [ADDR_W-1:0] paddr_i = '0;
    logic [DATA_W-1:0] pwdata_i = '0;
    logic [DATA_W-1:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [3:0] lvl = '0;
    logic [2:0] dlvl = '0;
    logic [3:0] din;
    logic [2:0] dio_in;
    logic [2:0] dio_out;
    logic [2:0] dio_oe;
    logic [15:0] dest_o;
    logic [31:0] seed = 32'h7517;
    logic [31:0] r;
    logic e;
    logic hit;
    logic [7:0] seen;
    int num_errors = 0;
    int num_checks = 0;
    int hits;
    int v;

    io_assignment_selector uut (.clock_i(clock_i), .nrst_i(nrst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .din_i(din),
        .dio_in_i(dio_in), .dio_out_o(dio_out), .dio_oe_o(dio_oe),
        .dest_o(dest_o));
    field_wiring wiring (.lvl_i(lvl), .dio_lvl_i(dlvl),
        .dio_out_i(dio_out), .dio_oe_i(dio_oe), .din_o(din),
        .dio_in_o(dio_in));

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic logic [31:0] w0(input int s, input int d);
        return 32'h8000_0000 | (d << 16) | s;
    endfunction

    task automatic report_and_stop;
        $display("counts: errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // Setup then access; request held until pready is seen high
    task automatic apb(input logic w, input int a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a[ADDR_W-1:0];
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        if (n >= 16) begin
            chk(1'b0, "no pready");
            report_and_stop();
        end
    endtask

    task automatic wr(input int a, input logic [31:0] d, input logic x);
        apb(1, a, d);
        chk(e === x, "write response");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic wt(input int i, input logic b, input int lim);
        int n;
        n = 0;
        while (dest_o[i] !== b && n < lim) begin
            @(negedge clock_i);
            n++;
        end
        hit = (dest_o[i] === b);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge clock_i);
            hits += $countones(dest_o[15:8]);
            seen |= dest_o[15:8];
        end
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1;
        @(negedge clock_i);
        chk(dest_o === 16'h0 && dio_oe === 3'h0 && dio_out === 3'h0,
            "reset outputs");
        apb(0, CTRL_ADDR, 0);
        chk(r === 32'h0, "ctrl reset value");
        apb(0, 12'h00C, 0);
        chk(e === 1'b1, "unmapped read");
        apb(0, 12'h002, 0);
        chk(e === 1'b1, "unaligned read");
        wr(STAT_ADDR, 32'hFF, 1);
        $display("test registers done");
        wr(DEB_BASE, 3, 0);
        wr(ASG_BASE, w0(0, 0), 0);
        apb(0, ASG_BASE + 4, 0);
        chk(r[1:0] === 2'h0, "default polarity");
        @(posedge clock_i);
        lvl[0] <= 1;
        repeat (2) @(posedge clock_i);
        lvl[0] <= 0;
        wt(0, 1, 14);
        chk(!hit, "short pulse passed");
        @(posedge clock_i);
        lvl[0] <= 1;
        cyc(5);
        chk(dest_o[0] === 1'b0, "early qualify");
        wt(0, 1, 10);
        chk(hit, "active on follow");
        wr(ASG_BASE + 4, 1, 0);
        wt(0, 0, 4);
        chk(hit, "active off high");
        @(posedge clock_i);
        lvl[0] <= 0;
        wt(0, 1, 12);
        chk(hit, "active off low");
        wr(ASG_BASE + 4, 32'h0001_0002, 0);
        @(posedge clock_i);
        lvl[1] <= 1;
        wt(0, 0, 8);
        chk(hit, "custom clear first");
        @(posedge clock_i);
        lvl[1] <= 0;
        lvl[0] <= 1;
        wt(0, 1, 12);
        chk(hit, "custom set");
        @(posedge clock_i);
        lvl[0] <= 0;
        cyc(12);
        chk(dest_o[0] === 1'b1, "custom latch");
        @(posedge clock_i);
        lvl[1] <= 1;
        wt(0, 0, 8);
        chk(hit, "custom clear");
        wr(ASG_BASE, w0(0, 0), 0);
        wr(ASG_BASE + 8, w0(1, 0), 0);
        wt(0, 1, 8);
        chk(hit, "fan-in or");
        @(posedge clock_i);
        lvl[1] <= 0;
        wt(0, 0, 8);
        chk(hit, "fan-in release");
        $display("test polarity done");
        wr(CTRL_ADDR, 15, 0);
        apb(0, CTRL_ADDR, 0);
        chk(r[3:0] === 4'h8, "line count clamp");
        wr(CTRL_ADDR, 3, 0);
        for (int k = 0; k < 3; k++) begin
            wr(ASG_BASE + 8 * (2 + k), w0(4 + k, 19 + k), 0);
        end
        wr(ASG_BASE + 40, w0(3, 27), 0);
        for (int k = 0; k < 8; k++) begin
            wr(ASG_BASE + 8 * (6 + k), w0(7 + k, 8 + k), 0);
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 0 : (i == 1) ? 7 : int'(seed[2:0]);
            @(posedge clock_i);
            dlvl <= v[2:0];
            cyc(5);
            hits = 0;
            seen = '0;
            @(posedge clock_i);
            lvl[3] <= 1;
            pulses(20);
            hit = (hits == 1 && seen === 8'(1 << v));
            chk(hit, "one selection");
            apb(0, STAT_ADDR, 0);
            chk(r[24:16] === {1'b1, 8'(v)}, "captured index");
            hits = 0;
            @(posedge clock_i);
            lvl[3] <= 0;
            dlvl <= ~v[2:0];
            pulses(10);
            chk(hits == 0, "select without trigger");
        end
        $display("test selector done");
        for (int k = 0; k < 11; k++) begin
            wr(ASG_BASE + 8 * k, w0(2, k), k == 10);
        end
        apb(0, ASG_BASE + 80, 0);
        chk(r === w0(11, 12), "refused write kept entry");
        wr(CTRL_ADDR, 32'h0000_0500, 0);
        @(posedge clock_i);
        dlvl <= 3'b010;
        cyc(4);
        chk(dio_oe === 3'b101, "direction enables");
        apb(0, STAT_ADDR, 0);
        chk(r[10:8] === 3'b010, "pin levels");
        wr(ASG_BASE + 88, w0(3, 16), 0);
        wr(ASG_BASE + 92, 1, 0);
        wr(ASG_BASE + 96, w0(3, 18), 0);
        wr(ASG_BASE + 100, 3, 0);
        cyc(3);
        chk(dio_out === 3'b001, "drive output levels");
        $display("test fan-out and drive io done");
        report_and_stop();
    end
endmodule
